// >>> verilog/reset_clock_pkg.sv
// constants shared by the reset and clock source controller
// assumes a 25 MHz system clock and an 8-bit register port
package reset_clock_pkg;
    // register port geometry and addresses
    localparam int unsigned     REG_ADDR_WIDTH        = 8;
    localparam int unsigned     REG_DATA_WIDTH        = 8;
    localparam logic [7:0]      POWER_CONTROL_ADDR    = 8'h87;
    localparam logic [7:0]      WATCHDOG_RESTART_ADDR = 8'hA6;
    localparam logic [7:0]      WATCHDOG_CONTROL_ADDR = 8'hA7;

    // power control fields and reset value
    localparam int unsigned     COLD_START_BIT        = 4;
    localparam int unsigned     POWER_DOWN_BIT        = 1;
    localparam logic [7:0]      POWER_CONTROL_RESET   = 8'h00;
    localparam logic [7:0]      POWER_CONTROL_MASK    = 8'hEF;

    // watchdog control fields and reset value
    localparam int unsigned     WDT_ENABLE_BIT        = 0;
    localparam int unsigned     WDT_EXPIRED_BIT       = 1;
    localparam int unsigned     WDT_PRESCALE_LSB      = 5;
    localparam logic [2:0]      WDT_PRESCALE_RESET    = 3'h0;
    localparam logic [7:0]      WDT_RESTART_FIRST     = 8'h1E;
    localparam logic [7:0]      WDT_RESTART_SECOND    = 8'hE1;

    // timing: clock, start-up delays, watchdog
    localparam int unsigned     CLOCK_PERIOD_NS       = 40;
    localparam int unsigned     POR_DELAY_US          = 2000;
    localparam int unsigned     BOD_DELAY_US          = 2000;
    localparam int unsigned     POR_DELAY_CYCLES      =
        (POR_DELAY_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned     BOD_DELAY_CYCLES      =
        (BOD_DELAY_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned     WDT_BASE_CYCLES       = 16384;
    localparam logic [4:0]      WDT_PULSE_CYCLES      = 5'h10;
    localparam logic [15:0]     RESET_VECTOR          = 16'h0000;
    localparam int unsigned     DELAY_WIDTH           = 20;
    localparam int unsigned     WDT_WIDTH             = 24;

    // restart sequence tracker
    typedef enum logic [1:0] {
        RESTART_IDLE  = 2'b01,
        RESTART_ARMED = 2'b10
    } restart_state_t;
endpackage

// >>> verilog/delay_if.sv
// hold/busy pair between the controller and one start-up delay counter
// assumes both ends share the system clock
`timescale 1ns/1ps
interface delay_if;
    logic hold;
    logic busy;
    modport owner   (output hold, input busy);
    modport counter (input hold, output busy);
endinterface

// >>> verilog/delay_counter.sv
// start-up delay counter: busy while held and for LIMIT cycles after
// assumes hold is synchronous to clock
`timescale 1ns/1ps
module delay_counter #(
    parameter int unsigned LIMIT      = 1,
    parameter bit          START_BUSY = 1'b1
) (
    input  wire logic clock,
    input  wire logic ce,
    input  wire logic nrst,
    delay_if.counter  link
);
    import reset_clock_pkg::*;

    logic [DELAY_WIDTH-1:0] count;
    logic                   busy_q;
    wire                    last_w = (count == DELAY_WIDTH'(LIMIT - 1));

    // restart on every hold, release after the full count
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            count  <= '0;
            busy_q <= START_BUSY;
        end
        else if (ce)
        begin
            if (link.hold)
            begin
                count  <= '0; // R3 R7
                busy_q <= 1'b1;
            end
            else if (busy_q)
            begin
                count  <= count + 1'b1;
                busy_q <= !last_w; // R3 R7
            end
        end
    end

    assign link.busy = busy_q;

    // hold forces busy, and busy stands while counting
    property p_hold_busy;
        @(posedge clock) disable iff (!nrst || !ce)
        link.hold |=> link.busy;
    endproperty
    a_hold_busy: assert property (p_hold_busy) else $error("delay not busy after hold"); // R7
endmodule

// >>> verilog/watchdog_timer.sv
// watchdog counter with 1EH/E1H restart sequence and one-cycle expiry pulse
// assumes nrst also carries the controller's internal reset
`timescale 1ns/1ps
module watchdog_timer #(
    parameter int unsigned BASE_CYCLES = reset_clock_pkg::WDT_BASE_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       ce,
    input  wire logic       nrst,
    input  wire logic       enable,
    input  wire logic [2:0] prescale,
    input  wire logic       restart_wr,
    input  wire logic [7:0] restart_data,
    output logic            expire
);
    import reset_clock_pkg::*;

    restart_state_t         state;
    restart_state_t         next_state;
    logic [WDT_WIDTH-1:0]   count;

    // restart only on the second byte right after the first
    wire kick_w = restart_wr && (state == RESTART_ARMED)
                  && (restart_data == WDT_RESTART_SECOND);
    wire [WDT_WIDTH-1:0] last_w = (WDT_WIDTH'(BASE_CYCLES) << prescale) - 1'b1;
    wire at_end_w = (count == last_w);

    // any other write breaks the sequence
    always_comb
    begin
        next_state = state;
        unique case (state)
            RESTART_IDLE,
            RESTART_ARMED:
                if (restart_wr)
                    next_state = (restart_data == WDT_RESTART_FIRST)
                                 ? RESTART_ARMED : RESTART_IDLE;
            default:
                next_state = RESTART_IDLE;
        endcase
    end

    // counts one per clock; a restart beats a same-cycle expiry
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            state  <= RESTART_IDLE;
            count  <= '0;
            expire <= 1'b0;
        end
        else if (ce)
        begin
            state  <= next_state;
            expire <= enable && at_end_w && !kick_w; // R13
            count  <= (!enable || kick_w || at_end_w) ? '0 : count + 1'b1; // R12
        end
    end

    property p_kick_clears;
        @(posedge clock) disable iff (!nrst || !ce)
        (kick_w && enable) |=> (count == '0) && !expire;
    endproperty
    a_kick_clears: assert property (p_kick_clears) else $error("restart did not clear"); // R12

    property p_disabled_quiet;
        @(posedge clock) disable iff (!nrst || !ce)
        !enable |=> !expire;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("expiry while off"); // R13
endmodule

// >>> verilog/reset_clock_control.sv
// reset and system clock source controller of a small 8-bit microcontroller
// assumes all pins synchronous to clock; registers on an 8-bit strobe port
// Function
// R1: during reset load initial values, tri-state ports; restart fetch at 0000H.
// R2: only four reset causes: supply-up, undervoltage, external pin, watchdog.
// R3: after supply rises, hold reset for the supply-up delay count.
// R4: supply falling below threshold reasserts reset at once.
// R5: supply-up reset sets the cold-start flag.
// R6: undervoltage enters reset at once, no counter.
// R7: undervoltage clearing starts its own delay; release after it expires.
// R8: external reset valid only after two consecutive high samples.
// R9: in-system programming only while external reset high and fuse set.
// R10: watchdog expiry gives an internal reset of exactly 16 cycles.
// R11: watchdog reset sets the watchdog expired flag.
// R12: software writes 1EH then E1H to the restart port in time.
// R13: every reset clears watchdog enable; expiry only while enabled.
// R14: CPU clock taken straight from the selected source, undivided.
// R15: bypass fuse disables the amplifier and uses the input pin.
// R16: clock-out fuse drives the clock on port 3 bit 7; one in power-down.
// R17: cold-start flag writable, untouched by warm resets.
// R18: internal reset is the OR of all sources, held until the last clears.
`timescale 1ns/1ps
module reset_clock_control #(
    parameter int unsigned POR_CYCLES  = reset_clock_pkg::POR_DELAY_CYCLES,
    parameter int unsigned BOD_CYCLES  = reset_clock_pkg::BOD_DELAY_CYCLES,
    parameter int unsigned WDT_CYCLES  = reset_clock_pkg::WDT_BASE_CYCLES
) (
    input  wire logic                                   clock,
    input  wire logic                                   ce,
    input  wire logic                                   nrst,
    input  wire logic                                   supply_ok,
    input  wire logic                                   undervoltage_detector,
    input  wire logic                                   ext_reset,
    input  wire logic                                   isp_fuse,
    input  wire logic                                   osc_bypass_fuse,
    input  wire logic                                   clock_out_fuse,
    input  wire logic                                   oscillator_input_pin,
    input  wire logic [reset_clock_pkg::REG_ADDR_WIDTH-1:0] addr,
    input  wire logic [reset_clock_pkg::REG_DATA_WIDTH-1:0] wdata,
    input  wire logic                                   wr,
    input  wire logic                                   rd,
    output logic [reset_clock_pkg::REG_DATA_WIDTH-1:0]  rdata,
    output logic                                        cpu_reset,
    output logic                                        port_tristate,
    output logic                                        fetch_start,
    output logic [15:0]                                 reset_vector,
    output logic                                        in_system_programming,
    output logic                                        osc_amp_enable,
    output logic                                        oscillator_output_pin,
    output logic                                        oscillator_output_pin_oe,
    output logic                                        cpu_clock_level,
    output logic                                        port3_bit7_clock_out,
    output logic                                        port3_bit7_clock_out_oe,
    output logic                                        cold_start_flag,
    output logic                                        watchdog_expired_flag,
    output logic                                        power_down
);
    import reset_clock_pkg::*;

    logic [7:0] power_control_reg;   // cold-start bit kept apart
    logic       wdt_enable;
    logic [2:0] wdt_prescale;
    logic       wdt_expire;
    logic [4:0] wdt_left;
    logic       ext_prev;
    logic       ext_hit;

    delay_if por_link ();
    delay_if bod_link ();

    // register port decode
    wire power_control_reg_wr_w   = wr && (addr == POWER_CONTROL_ADDR);
    wire watchdog_control_reg_wr_w = wr && (addr == WATCHDOG_CONTROL_ADDR);
    wire restart_w   = wr && (addr == WATCHDOG_RESTART_ADDR);
    wire wdt_nrst_w  = nrst && !(ce && cpu_reset); // R13

    // read selection; the restart port is write-only and reads zero
    wire [7:0] power_control_reg_view_w = {power_control_reg[7:5], cold_start_flag,
                              power_control_reg[3:0]};
    wire [7:0] watchdog_control_reg_view_w = {wdt_prescale, 3'h0, watchdog_expired_flag, wdt_enable};
    wire [7:0] read_mux_w = (addr == POWER_CONTROL_ADDR)    ? power_control_reg_view_w
                          : (addr == WATCHDOG_CONTROL_ADDR) ? watchdog_control_reg_view_w
                          : 8'h00;

    // supply-up and undervoltage delays each own a counter
    assign por_link.hold = !supply_ok; // R3 R4
    assign bod_link.hold = undervoltage_detector; // R6 R7

    delay_counter #(
        .LIMIT      (POR_CYCLES),
        .START_BUSY (1'b1)
    ) u_por_delay (
        .clock (clock),
        .ce    (ce),
        .nrst  (nrst),
        .link  (por_link)
    );

    delay_counter #(
        .LIMIT      (BOD_CYCLES),
        .START_BUSY (1'b0)
    ) u_bod_delay (
        .clock (clock),
        .ce    (ce),
        .nrst  (nrst),
        .link  (bod_link)
    );

    watchdog_timer #(
        .BASE_CYCLES (WDT_CYCLES)
    ) u_watchdog (
        .clock        (clock),
        .ce           (ce),
        .nrst         (wdt_nrst_w),
        .enable       (wdt_enable),
        .prescale     (wdt_prescale),
        .restart_wr   (restart_w),
        .restart_data (wdata),
        .expire       (wdt_expire)
    );

    // the four causes, combined; a detector edge reaches the pin next cycle
    wire wdt_active_w = (wdt_left != 5'h00);
    wire next_reset = !supply_ok || por_link.busy       // R2 R4 R18
                    || undervoltage_detector || bod_link.busy // R6 R7
                    || ext_hit || wdt_active_w;          // R8 R10

    // clock source: amplifier inverts the input pin unless bypassed
    wire sel_level_w = osc_bypass_fuse ? oscillator_input_pin // R15
                                       : !oscillator_input_pin;

    // external pin filter: two high samples in a row
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            ext_prev <= 1'b0;
            ext_hit  <= 1'b0;
        end
        else if (ce)
        begin
            ext_prev <= ext_reset;
            ext_hit  <= ext_reset && ext_prev; // R8
        end
    end

    // watchdog reset pulse length, reloaded on expiry
    always_ff @(posedge clock)
    begin
        if (!nrst)
            wdt_left <= 5'h00;
        else if (ce)
            wdt_left <= wdt_expire ? WDT_PULSE_CYCLES // R10
                      : wdt_active_w ? wdt_left - 5'h01 : 5'h00;
    end

    // internal reset and its effect on the core
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            cpu_reset     <= 1'b1;
            port_tristate <= 1'b1;
            fetch_start   <= 1'b0;
            reset_vector  <= RESET_VECTOR;
        end
        else if (ce)
        begin
            cpu_reset     <= next_reset; // R18
            port_tristate <= next_reset; // R1
            fetch_start   <= cpu_reset && !next_reset; // R1
            reset_vector  <= RESET_VECTOR;
        end
    end

    // power control; cleared by every reset except the cold-start bit
    always_ff @(posedge clock)
    begin
        if (!nrst || (ce && cpu_reset))
            power_control_reg <= POWER_CONTROL_RESET; // R1
        else if (ce && power_control_reg_wr_w)
            power_control_reg <= wdata & POWER_CONTROL_MASK;
    end

    // cold-start flag: supply loss sets it and wins over a write
    always_ff @(posedge clock)
    begin
        if (!nrst)
            cold_start_flag <= 1'b1;
        else if (ce)
            cold_start_flag <= !supply_ok // R5
                || (power_control_reg_wr_w ? wdata[COLD_START_BIT] : cold_start_flag); // R17
    end

    // watchdog control; enable cleared by any reset
    always_ff @(posedge clock)
    begin
        if (!nrst || (ce && cpu_reset))
        begin
            wdt_enable   <= 1'b0; // R13
            wdt_prescale <= WDT_PRESCALE_RESET;
        end
        else if (ce && watchdog_control_reg_wr_w)
        begin
            wdt_enable   <= wdata[WDT_ENABLE_BIT];
            wdt_prescale <= wdata[WDT_PRESCALE_LSB +: 3];
        end
    end

    // expired flag survives the reset it causes; set wins over a clear
    always_ff @(posedge clock)
    begin
        if (!nrst)
            watchdog_expired_flag <= 1'b0;
        else if (ce)
            watchdog_expired_flag <= wdt_expire // R11
                || (watchdog_control_reg_wr_w ? wdata[WDT_EXPIRED_BIT] : watchdog_expired_flag);
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clock)
    begin
        if (!nrst)
            rdata <= 8'h00;
        else if (ce)
            rdata <= rd ? read_mux_w : 8'h00;
    end

    // clock outputs registered; level copies, so no division anywhere
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            in_system_programming    <= 1'b0;
            osc_amp_enable           <= 1'b0;
            oscillator_output_pin    <= 1'b0;
            oscillator_output_pin_oe <= 1'b0;
            cpu_clock_level          <= 1'b0;
            port3_bit7_clock_out     <= 1'b1;
            port3_bit7_clock_out_oe  <= 1'b0;
            power_down               <= 1'b0;
        end
        else if (ce)
        begin
            in_system_programming    <= ext_reset && isp_fuse; // R9
            osc_amp_enable           <= !osc_bypass_fuse; // R15
            oscillator_output_pin    <= !oscillator_input_pin;
            oscillator_output_pin_oe <= !osc_bypass_fuse; // R15
            cpu_clock_level          <= sel_level_w; // R14
            power_down               <= power_control_reg[POWER_DOWN_BIT];
            port3_bit7_clock_out     <= power_control_reg[POWER_DOWN_BIT] // R16
                                        || sel_level_w;
            port3_bit7_clock_out_oe  <= clock_out_fuse && !next_reset; // R16 R1
        end
    end

    // checks on the combined reset, in-system programming and the clock-out pin
    property p_supply_drop;
        @(posedge clock) disable iff (!nrst || !ce)
        !supply_ok |=> cpu_reset && cold_start_flag;
    endproperty
    a_supply_drop: assert property (p_supply_drop) else $error("supply drop missed"); // R4

    property p_undervoltage;
        @(posedge clock) disable iff (!nrst || !ce)
        undervoltage_detector |=> cpu_reset ##1 cpu_reset;
    endproperty
    a_undervoltage: assert property (p_undervoltage) else $error("undervoltage missed"); // R6

    property p_ext_two;
        @(posedge clock) disable iff (!nrst || !ce)
        (ext_reset ##1 ext_reset) |=> ##1 cpu_reset;
    endproperty
    a_ext_two: assert property (p_ext_two) else $error("external reset missed"); // R8

    property p_wdt_pulse;
        @(posedge clock) disable iff (!nrst || !ce)
        $rose(wdt_active_w) |-> ##15 wdt_active_w ##1 !wdt_active_w;
    endproperty
    a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog pulse length"); // R10

    property p_wdt_flag;
        @(posedge clock) disable iff (!nrst || !ce)
        wdt_expire |=> watchdog_expired_flag ##1 cpu_reset;
    endproperty
    a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not set"); // R11

    property p_enable_cleared;
        @(posedge clock) disable iff (!nrst || !ce)
        cpu_reset |=> !wdt_enable;
    endproperty
    a_enable_cleared: assert property (p_enable_cleared) else $error("enable kept"); // R13

    property p_isp;
        @(posedge clock) disable iff (!nrst || !ce)
        in_system_programming |-> $past(ext_reset) && $past(isp_fuse);
    endproperty
    a_isp: assert property (p_isp) else $error("programming without pin"); // R9

    property p_clock_out_pd;
        @(posedge clock) disable iff (!nrst || !ce)
        power_control_reg[POWER_DOWN_BIT] |=> port3_bit7_clock_out;
    endproperty
    a_clock_out_pd: assert property (p_clock_out_pd) else $error("clock out not high"); // R16

    property p_release_fetch;
        @(posedge clock) disable iff (!nrst || !ce)
        $fell(cpu_reset) |-> fetch_start && (reset_vector == RESET_VECTOR);
    endproperty
    a_release_fetch: assert property (p_release_fetch) else $error("no fetch"); // R1

    property p_tristate;
        @(posedge clock) disable iff (!nrst || !ce)
        cpu_reset |-> port_tristate && !port3_bit7_clock_out_oe;
    endproperty
    a_tristate: assert property (p_tristate) else $error("port driven in reset"); // R1

    c_wdt_reset: cover property (@(posedge clock) disable iff (!nrst) wdt_expire);
    c_ext_reset: cover property (@(posedge clock) disable iff (!nrst) $rose(ext_hit));
    c_bod_reset: cover property (@(posedge clock) disable iff (!nrst) $fell(bod_link.busy));
    c_release:   cover property (@(posedge clock) disable iff (!nrst) fetch_start);
endmodule

// >>> tb/board_model.sv
// board side: supply monitor, undervoltage sense, reset pin and clock source
// assumes the bench calls its tasks from the system clock domain
`timescale 1ns/1ps
module board_model (
    input  wire logic clock,
    output logic      supply_ok             = 1'b1,
    output logic      undervoltage_detector = 1'b0,
    output logic      ext_reset             = 1'b0,
    output logic      oscillator_input_pin  = 1'b0
);
    // the source clock runs free, so the pin flips every cycle
    always @(posedge clock) oscillator_input_pin <= ~oscillator_input_pin;
    task automatic set_supply(input logic v);
        @(posedge clock);
        supply_ok <= v;
    endtask
    task automatic set_uv(input logic v);
        @(posedge clock);
        undervoltage_detector <= v;
    endtask
    // high for n sampling edges; n of one is a deliberate glitch
    task automatic ext_pulse(input int n);
        @(posedge clock);
        ext_reset <= 1'b1;
        repeat (n) @(posedge clock);
        ext_reset <= 1'b0;
    endtask
endmodule

// >>> tb/tb_reset_and_clock_source_control.sv
// bench for the reset and clock source controller
// assumes board_model on the pins; short delay and watchdog counts
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_reset_and_clock_source_control;
    import reset_clock_pkg::*;
    logic        clock, nrst, wr, rd, isp_fuse, osc_bypass_fuse, clock_out_fuse;
    logic [7:0]  addr, wdata, rdata, d;
    logic        supply_ok, undervoltage_detector, ext_reset, osc_pin;
    logic        cpu_reset, port_tristate, fetch_start, isp_on, amp_en, cpu_clk;
    logic        p3_clk, p3_oe, cold_flag, wdt_flag, seen, held, f, p, ce, osc_out, osc_oe, pd;
    logic [15:0] reset_vector;
    int          fail_count, n_compared, n;

    board_model board (.clock(clock), .supply_ok(supply_ok),
        .undervoltage_detector(undervoltage_detector), .ext_reset(ext_reset),
        .oscillator_input_pin(osc_pin));
    reset_clock_control #(.POR_CYCLES(8), .BOD_CYCLES(8), .WDT_CYCLES(16)) uut (
        .clock(clock), .ce(ce), .nrst(nrst), .supply_ok(supply_ok),
        .undervoltage_detector(undervoltage_detector), .ext_reset(ext_reset),
        .isp_fuse(isp_fuse), .osc_bypass_fuse(osc_bypass_fuse),
        .clock_out_fuse(clock_out_fuse), .oscillator_input_pin(osc_pin),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .cpu_reset(cpu_reset), .port_tristate(port_tristate), .fetch_start(fetch_start),
        .reset_vector(reset_vector), .in_system_programming(isp_on),
        .osc_amp_enable(amp_en), .oscillator_output_pin(osc_out),
        .oscillator_output_pin_oe(osc_oe),
        .cpu_clock_level(cpu_clk), .port3_bit7_clock_out(p3_clk),
        .port3_bit7_clock_out_oe(p3_oe), .cold_start_flag(cold_flag),
        .watchdog_expired_flag(wdt_flag), .power_down(pd));

    // 25 MHz
    always #20 clock = ~clock;

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask
    // read data stand one cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        @(negedge clock);
        d = rdata;
    endtask
    // cycles until cpu_reset shows v; a hang ends the run
    task automatic wait_level(input logic v, input int lim);
        n = 0;
        @(negedge clock);
        while (cpu_reset !== v)
        begin
            n++;
            if (n > lim)
            begin
                fail_count++;
                $display("ERROR cpu_reset wait expected %0h seen timeout", v);
                complete_run;
            end
            @(negedge clock);
        end
    endtask
    task automatic watch(input int k);
        seen = 1'b0;
        held = 1'b1;
        repeat (k)
        begin
            @(negedge clock);
            seen = seen | cpu_reset;
            held = held & cpu_reset;
        end
    endtask

    task automatic t_reset;
        @(negedge clock);
        `CHK("cpu_reset", 1'b1, cpu_reset)
        `CHK("tristate", 1'b1, port_tristate)
        `CHK("vector", 16'h0000, reset_vector)
        `CHK("p3_oe", 1'b0, p3_oe)
        `CHK("wdt_flag", 1'b0, wdt_flag)
        wait_level(1'b0, 40);
        `CHK("por_hold", 1'b1, n >= 7 && n <= 11)
        f = fetch_start;
        @(negedge clock);
        `CHK("fetch", 1'b1, f | fetch_start)
        `CHK("released", 1'b0, port_tristate)
        rd_reg(POWER_CONTROL_ADDR);
        `CHK("power_control_reg", 8'h10, d)
        wr_reg(POWER_CONTROL_ADDR, 8'h00);
        rd_reg(POWER_CONTROL_ADDR);
        `CHK("power_control_reg_clr", 8'h00, d)
        $display("t_reset done");
    endtask
    task automatic t_ext;
        board.ext_pulse(1);
        watch(4);
        `CHK("glitch", 1'b0, seen)
        fork
            board.ext_pulse(6);
            begin
                repeat (5) @(negedge clock);
                `CHK("ext_rst", 1'b1, cpu_reset)
                `CHK("isp_on", 1'b1, isp_on)
                `CHK("p3_oe_rst", 1'b0, p3_oe)
                isp_fuse <= 1'b0;
                @(negedge clock) `CHK("isp_fuse", 1'b0, isp_on)
            end
        join
        wait_level(1'b0, 20);
        `CHK("isp_off", 1'b0, isp_on)
        `CHK("cold_kept", 1'b0, cold_flag)
        $display("t_ext done");
    endtask
    task automatic t_supply;
        board.set_uv(1'b1);
        repeat (3) @(negedge clock);
        `CHK("uv_rst", 1'b1, cpu_reset)
        board.set_uv(1'b0);
        wait_level(1'b0, 20);
        `CHK("uv_hold", 1'b1, n >= 8 && n <= 12)
        `CHK("cold_warm", 1'b0, cold_flag)
        board.set_supply(1'b0);
        repeat (3) @(negedge clock);
        `CHK("supply_rst", 1'b1, cpu_reset)
        `CHK("cold_set", 1'b1, cold_flag)
        board.set_uv(1'b1);
        board.set_supply(1'b1);
        watch(15);
        `CHK("last_src", 1'b1, held)
        board.set_uv(1'b0);
        wait_level(1'b0, 20);
        `CHK("uv_hold2", 1'b1, n >= 8 && n <= 12)
        $display("t_supply done");
    endtask
    task automatic t_wdt;
        wr_reg(WATCHDOG_CONTROL_ADDR, 8'h01);
        rd_reg(WATCHDOG_CONTROL_ADDR);
        `CHK("wdt_en", 8'h01, d)
        repeat (6)
        begin
            wr_reg(WATCHDOG_RESTART_ADDR, 8'h1E);
            wr_reg(WATCHDOG_RESTART_ADDR, 8'hE1);
        end
        @(negedge clock);
        `CHK("restarted", 1'b0, cpu_reset | wdt_flag)
        rd_reg(WATCHDOG_RESTART_ADDR);
        `CHK("wo_port", 8'h00, d)
        rd_reg(8'h55);
        `CHK("unmapped", 8'h00, d)
        wait_level(1'b1, 100);
        wait_level(1'b0, 40);
        `CHK("wdt_pulse", 16, n + 1)
        `CHK("wdt_flag", 1'b1, wdt_flag)
        rd_reg(WATCHDOG_CONTROL_ADDR);
        `CHK("wdt_off", 8'h02, d)
        watch(40);
        `CHK("no_expiry", 1'b0, seen)
        wr_reg(WATCHDOG_CONTROL_ADDR, 8'h00);
        rd_reg(WATCHDOG_CONTROL_ADDR);
        `CHK("flag_clr", 8'h00, d)
        $display("t_wdt done");
    endtask
    task automatic t_clock;
        for (int b = 0; b < 2; b++)
        begin
            @(posedge clock);
            osc_bypass_fuse <= b[0];
            clock_out_fuse  <= 1'b1;
            repeat (3) @(negedge clock);
            p = osc_pin;
            repeat (4)
            begin
                @(negedge clock);
                `CHK("cpu_clk", b[0] ? p : ~p, cpu_clk)
                `CHK("p3_clk", b[0] ? p : ~p, p3_clk)
                `CHK("osc_out", ~p, osc_out)
                p = osc_pin;
            end
            `CHK("amp_en", ~b[0], amp_en)
            `CHK("osc_oe", ~b[0], osc_oe)
            `CHK("p3_oe_on", 1'b1, p3_oe)
        end
        wr_reg(POWER_CONTROL_ADDR, 8'h02);
        repeat (2) @(negedge clock);
        f = 1'b1;
        repeat (4)
        begin
            @(negedge clock);
            f = f & p3_clk & pd;
        end
        `CHK("pd_high", 1'b1, f)
        @(posedge clock) ce <= 1'b0;
        @(negedge clock) p = cpu_clk;
        repeat (3) @(negedge clock);
        `CHK("frozen", p, cpu_clk)
        @(posedge clock) {ce, clock_out_fuse} <= 2'b10;
        repeat (2) @(negedge clock);
        `CHK("p3_oe_off", 1'b0, p3_oe)
        $display("t_clock done");
    endtask

    initial
    begin
        {nrst, wr, rd, osc_bypass_fuse, clock_out_fuse} = '0;
        {clock, isp_fuse, ce} = 3'b011;
        addr = 8'h00;
        wdata = 8'h00;
        fail_count = 0;
        n_compared = 0;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        t_reset;
        t_ext;
        t_supply;
        t_wdt;
        t_clock;
        complete_run;
    end
endmodule
